// *** rtl/mmi_support.sv ***
// Shared constants and the memory-port arbiter for the multiplier interlock
`timescale 1ns/10ps
`default_nettype none

package mmi_pkg;
    // Transfer kinds presented with a transfer request
    localparam logic XFER_STORE_MEM = 1'h0;
    localparam logic XFER_LOAD_REG  = 1'h1;
    // Value after reset of every control flop
    localparam logic RESET_LOW      = 1'h0;
    // Documented width of a multiply-accumulate register word
    localparam int   MAC_WIDTH      = 32;
    typedef enum logic [0:0] {
        MMI_IDLE   = 1'h0,
        MMI_ACCESS = 1'h1
    } mmi_state_type;
endpackage

// Memory-access stage owns the port; fetch is deferred to the next free slot
module mmi_bus_arbiter (
    input  wire logic acc_req,
    input  wire logic fetch_req,
    output logic      acc_grant,
    output logic      fetch_grant
);
    // Fixed priority, as for every access versus fetch conflict
    assign acc_grant   = acc_req;
    assign fetch_grant = fetch_req && !acc_req;
endmodule // mmi_bus_arbiter

`default_nettype wire

// *** rtl/mmi_interlock.sv ***
// Interlock of system-register transfers against a running signed word multiply
`timescale 1ns/10ps
`default_nettype none

module mmi_interlock
    import mmi_pkg::*;
#(
    parameter int DATA_WIDTH = MAC_WIDTH
) (
    input  wire logic                  mclk,
    input  wire logic                  reset,
    input  wire logic                  xfer_valid,
    input  wire logic                  xfer_kind,
    input  wire logic [DATA_WIDTH-1:0] gpr_rdata,
    input  wire logic                  mult_busy,
    input  wire logic                  mult_last,
    input  wire logic [DATA_WIDTH-1:0] mac_rdata,
    input  wire logic                  fetch_req,
    output logic                       fetch_grant,
    output logic                       pipe_hold,
    output logic                       stage_active,
    output logic                       mem_wr_en,
    output logic [DATA_WIDTH-1:0]      mem_wr_data,
    output logic                       mac_wr_en,
    output logic [DATA_WIDTH-1:0]      mac_wr_data,
    output logic                       slot_done
);

    // Only full MAC words are supported by the write paths
    if (DATA_WIDTH != MAC_WIDTH)
    begin : g_width_check
        $error("mmi_interlock: DATA_WIDTH must equal the MAC width");
    end

    mmi_state_type         state_reg;
    logic                  kind_reg;
    logic [DATA_WIDTH-1:0] gpr_reg;
    logic                  done;
    logic                  acc_req;
    logic                  acc_grant;
    logic                  mem_wr_en_reg;
    logic                  mac_wr_en_reg;
    logic                  slot_done_reg;
    logic [DATA_WIDTH-1:0] mem_wr_data_reg;
    logic [DATA_WIDTH-1:0] mac_wr_data_reg;

    // Completion test per transfer kind
    function automatic logic stage_complete(input logic kind, input logic busy, input logic last);
        if (kind == XFER_STORE_MEM)
            stage_complete = !busy;
        else
            stage_complete = !busy || last;
    endfunction

    assign done = (state_reg == MMI_ACCESS) && stage_complete(kind_reg, mult_busy, mult_last);

    // Completing cycle is the single bus slot of the stage
    assign acc_req = done;

    // Fetch yields the port while the access completes
    mmi_bus_arbiter u_arb (
        .acc_req     (acc_req),
        .fetch_req   (fetch_req),
        .acc_grant   (acc_grant),
        .fetch_grant (fetch_grant)
    );

    // Hold younger stages for the whole stretched stage, release in the cycle after its slot
    assign pipe_hold    = (state_reg == MMI_ACCESS);
    assign stage_active = (state_reg == MMI_ACCESS);

    // Stage sequencing; new transfers are ignored while one is in flight
    always_ff @(posedge mclk)
    begin
        if (reset)
            state_reg <= MMI_IDLE;
        else
        begin
            unique case (state_reg)
                MMI_IDLE:
                    if (xfer_valid)
                        state_reg <= MMI_ACCESS;
                MMI_ACCESS:
                    if (done)
                        state_reg <= MMI_IDLE;
            endcase
        end
    end

    // Capture the transfer when it enters its access stage
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            kind_reg <= XFER_STORE_MEM;
            gpr_reg  <= '0;
        end
        else if (state_reg == MMI_IDLE && xfer_valid)
        begin
            kind_reg <= xfer_kind;
            gpr_reg  <= gpr_rdata;
        end
    end

    // Writes are issued from flops in the cycle after the granted slot
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            mem_wr_en_reg   <= RESET_LOW;
            mac_wr_en_reg   <= RESET_LOW;
            slot_done_reg   <= RESET_LOW;
            mem_wr_data_reg <= '0;
            mac_wr_data_reg <= '0;
        end
        else
        begin
            mem_wr_en_reg <= acc_grant && kind_reg == XFER_STORE_MEM;
            mac_wr_en_reg <= acc_grant && kind_reg == XFER_LOAD_REG;
            slot_done_reg <= acc_grant;
            if (acc_grant && kind_reg == XFER_STORE_MEM)
                mem_wr_data_reg <= mac_rdata;   // MAC read once the multiply has settled
            if (acc_grant && kind_reg == XFER_LOAD_REG)
                mac_wr_data_reg <= gpr_reg;
        end
    end

    assign mem_wr_en   = mem_wr_en_reg;
    assign mac_wr_en   = mac_wr_en_reg;
    assign slot_done   = slot_done_reg;
    assign mem_wr_data = mem_wr_data_reg;
    assign mac_wr_data = mac_wr_data_reg;

    // Store never completes while the multiplier is still busy
    AST_STORE_WAITS: assert property (
        @(posedge mclk) disable iff (reset)
        (state_reg == MMI_ACCESS && kind_reg == XFER_STORE_MEM && mult_busy) |-> !done)
        else $error("store stage completed during a busy cycle");

    // Store completes in the first free cycle after busy ends
    AST_STORE_EXTRA_CYCLE: assert property (
        @(posedge mclk) disable iff (reset)
        (state_reg == MMI_ACCESS && kind_reg == XFER_STORE_MEM && $fell(mult_busy)) |-> done)
        else $error("store stage not done one cycle after busy");

    // Load waits while the multiplier still has busy cycles to come
    AST_LOAD_WAITS: assert property (
        @(posedge mclk) disable iff (reset)
        (state_reg == MMI_ACCESS && kind_reg == XFER_LOAD_REG && mult_busy && !mult_last) |-> !done)
        else $error("load stage completed before the last busy cycle");

    // Load completes in the final busy cycle itself
    AST_LOAD_NO_EXTRA: assert property (
        @(posedge mclk) disable iff (reset)
        (state_reg == MMI_ACCESS && kind_reg == XFER_LOAD_REG && mult_busy && mult_last) |=> !pipe_hold)
        else $error("load stage overran the last busy cycle");

    // Store slot produces exactly one memory write of the MAC value
    AST_STORE_WRITES: assert property (
        @(posedge mclk) disable iff (reset)
        (done && kind_reg == XFER_STORE_MEM) |=> mem_wr_en && !mac_wr_en && mem_wr_data == $past(mac_rdata))
        else $error("store slot did not write memory");

    // Load slot writes the captured register into the MAC
    AST_LOAD_WRITES: assert property (
        @(posedge mclk) disable iff (reset)
        (done && kind_reg == XFER_LOAD_REG) |=> mac_wr_en && !mem_wr_en && mac_wr_data == $past(gpr_reg))
        else $error("load slot did not write the MAC");

    // The two write strobes never fire together
    AST_WRITES_EXCLUSIVE: assert property (
        @(posedge mclk) disable iff (reset)
        !(mem_wr_en && mac_wr_en))
        else $error("memory and MAC written in one cycle");

    // One stretched stage yields one slot, so the completion pulse never repeats
    AST_SLOT_SINGLE: assert property (
        @(posedge mclk) disable iff (reset)
        slot_done |=> !slot_done)
        else $error("access slot reported twice");

    // Fetch never shares the slot with the access
    AST_FETCH_DEFERRED: assert property (
        @(posedge mclk) disable iff (reset)
        (done && fetch_req) |-> !fetch_grant)
        else $error("fetch granted during access slot");

    // Fetch proceeds in the cycle after the access slot
    AST_FETCH_RESUMES: assert property (
        @(posedge mclk) disable iff (reset)
        (done ##1 fetch_req) |-> fetch_grant)
        else $error("fetch still blocked after access slot");

    // Outside an access stage fetch owns the port outright
    AST_FETCH_FREE_IDLE: assert property (
        @(posedge mclk) disable iff (reset)
        !pipe_hold |-> fetch_grant == fetch_req)
        else $error("fetch blocked with no access stage");

    // Fetch is free whenever no access stage completes
    AST_SLOT_SPLIT: assert property (
        @(posedge mclk) disable iff (reset)
        (pipe_hold && !done && fetch_req) |-> fetch_grant)
        else $error("fetch blocked during stretch");

    // Younger stages held from the cycle after entry
    AST_HOLD_ENTRY: assert property (
        @(posedge mclk) disable iff (reset)
        (!pipe_hold && xfer_valid) |=> pipe_hold)
        else $error("hold not raised after entry");

    // Hold stays up while the stage is still stretched
    AST_HOLD_KEEP: assert property (
        @(posedge mclk) disable iff (reset)
        (pipe_hold && !done) |=> pipe_hold)
        else $error("hold dropped before completion");

    // Younger stages resume in the cycle after completion
    AST_HOLD_RELEASE: assert property (
        @(posedge mclk) disable iff (reset)
        done |=> !pipe_hold)
        else $error("hold kept after completion");

    // A request arriving while held must not disturb the captured transfer
    AST_REQ_IGNORED: assert property (
        @(posedge mclk) disable iff (reset)
        (pipe_hold && !done) |=> $stable(kind_reg) && $stable(gpr_reg))
        else $error("transfer overwritten while held");

endmodule // mmi_interlock

`default_nettype wire

// *** tb/mmi_mult_model.sv ***
// Behavioural multiplier: busy run of a set length, MAC word stepping while busy
`timescale 1ns/10ps
`default_nettype none
module mmi_mult_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic [3:0]  len,
    output logic             mult_busy,
    output logic             mult_last,
    output logic [31:0]      mac_rdata
);
    logic [3:0] cnt_reg;
    // Busy run counts down from the requested length
    always_ff @(posedge mclk)
    begin
        if (reset)
            cnt_reg <= 4'h0;
        else if (start)
            cnt_reg <= len;
        else if (cnt_reg != 4'h0)
            cnt_reg <= cnt_reg - 4'h1;
    end
    // Word moves every busy cycle, so an early sample shows a stale value
    always_ff @(posedge mclk)
    begin
        if (reset)
            mac_rdata <= 32'h1234_5678;
        else if (mult_busy)
            mac_rdata <= mac_rdata * 32'h5 + 32'h1;
    end
    // Last flags the final busy cycle only
    assign mult_busy = (cnt_reg != 4'h0);
    assign mult_last = (cnt_reg == 4'h1);
endmodule // mmi_mult_model
`default_nettype wire

// *** tb/tb_mmi_interlock.sv ***
// Self-checking bench for the multiplier interlock
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_mmi_interlock;
    import mmi_pkg::*;
    logic        mclk, reset, xfer_valid, xfer_kind, start, fetch_req, mult_busy, mult_last;
    logic        fetch_grant, pipe_hold, stage_active, mem_wr_en, mac_wr_en, slot_done;
    logic [3:0]  len;
    logic [31:0] gpr_rdata, mac_rdata, mem_wr_data, mac_wr_data, mac_exp;
    int          n_mismatch, n_tests, done;
    mmi_interlock i_dut (.mclk, .reset, .xfer_valid, .xfer_kind, .gpr_rdata, .mult_busy, .mult_last,
        .mac_rdata, .fetch_req, .fetch_grant, .pipe_hold, .stage_active, .mem_wr_en, .mem_wr_data,
        .mac_wr_en, .mac_wr_data, .slot_done);
    mmi_mult_model i_mult (.mclk, .reset, .start, .len, .mult_busy, .mult_last, .mac_rdata);
    // Free-running core clock
    initial
    begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end
    task automatic give_verdict();
        $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Stage cycles up to the slot: store one past the busy run, load with its last cycle
    function automatic int exp_done(input logic kind, input int n);
        if (kind == XFER_STORE_MEM)
            return (n > 1) ? n : 1;
        return (n > 2) ? n - 1 : 1;
    endfunction
    // Multiply of n busy cycles, then a transfer straight behind it
    task automatic xfer(input logic kind, input logic [3:0] n, input logic fr);
        @(posedge mclk);
        #1 start = 1'h1;
        len = n;
        fetch_req = fr;
        @(posedge mclk);
        #1 start = 1'h0;
        xfer_valid = 1'h1;
        xfer_kind = kind;
        gpr_rdata = $urandom;
        done = exp_done(kind, n);
        for (int k = 1; k <= done + 1; k++)
        begin
            @(posedge mclk);
            // A second request of the other kind inside a long stretch must be ignored
            #1 xfer_valid = 1'(k == 1 && done > 1);
            xfer_kind = ~kind;
            `CHK(pipe_hold, 1'(k <= done))
            `CHK(stage_active, 1'(k <= done))
            `CHK(fetch_grant, 1'(fr && k != done))
            `CHK(slot_done, 1'(k > done))
            if (k == done)
                mac_exp = mac_rdata;
            if (k > done)
            begin
                `CHK(mem_wr_en, 1'(kind == XFER_STORE_MEM))
                `CHK(mac_wr_en, 1'(kind == XFER_LOAD_REG))
                `CHK(kind ? mac_wr_data : mem_wr_data, kind ? gpr_rdata : mac_exp)
            end
        end
    endtask
    // Corner table of short runs, then random runs
    initial
    begin
        reset = 1'h1;
        xfer_valid = 1'h0;
        xfer_kind = 1'h0;
        start = 1'h0;
        len = 4'h0;
        fetch_req = 1'h0;
        gpr_rdata = 32'h0;
        n_mismatch = 0;
        n_tests = 0;
        void'($urandom(32'h467e));
        repeat (10) @(posedge mclk);
        #1 reset = 1'h0;
        `CHK(pipe_hold, 1'h0)
        for (int i = 0; i < 12; i++)
            xfer(i[0], 4'(i / 2), 1'h1);
        for (int i = 0; i < 30; i++)
            xfer(1'($urandom), 4'($urandom_range(0, 9)), 1'($urandom));
        give_verdict();
    end
endmodule // tb_mmi_interlock
`default_nettype wire
